/* File: verilog/pqm_pkg.sv */
// Package for the 802.1p priority to queue mapper.
// Assumes an AXI4-Lite master with 32-bit data on the core clock.
// Contract
// - PCP 0 takes low map register bits 1:0, reset 0.
// - PCP 1 takes low map register bits 3:2, reset 0.
// - PCP 2 takes low map register bits 5:4, reset 1.
// - PCP 3 takes low map register bits 7:6, reset 1.
// - PCP 4 takes high map register bits 1:0, reset 2.
// - PCP 5 takes high map register bits 3:2, reset 2.
// - PCP 6 takes high map register bits 5:4, reset 3.
// - PCP 7 takes high map register bits 7:6, reset 3.
// - Two-queue mode steers any 2-bit result, 802.1p or DiffServ, low/high.
// - Two-queue mode: result 0 always goes low.
// - Two-queue mode: result 3 always goes high.
// - Result 1 uses split bit 0, result 2 split bit 1; 1 means high.
// - Split 00: results 0,1,2 low, 3 high.
// - Split 10, reset value in bits 7:6: results 0,1 low, 2,3 high.
// - Split 11: result 0 low, results 1,2,3 high.
// - Four-queue mode: mapped priority is the queue number, 3 highest.
package pqm_pkg;
	// Printed offsets are not word multiples: these are indices
	localparam logic [7:0] PQM_IDX_LOW_MAP   = 8'h80;
	localparam logic [7:0] PQM_IDX_HIGH_MAP  = 8'h81;
	localparam logic [7:0] PQM_IDX_SPLIT     = 8'h82;
	localparam logic [7:0] PQM_IDX_MODE      = 8'h83;
	localparam logic [7:0] PQM_RST_LOW_MAP   = 8'h50;
	localparam logic [7:0] PQM_RST_HIGH_MAP  = 8'hfa;
	localparam logic [1:0] PQM_RST_SPLIT     = 2'h2;
	localparam int         PQM_SPLIT_LSB     = 6;
	localparam int         PQM_FIELD_W       = 2;
	localparam logic [1:0] PQM_RESP_OKAY     = 2'h0;
	localparam logic [1:0] PQM_RESP_SLVERR   = 2'h2;
endpackage

/* File: verilog/pqm_mapper.sv */
// 802.1p priority mapper with two-queue split, AXI4-Lite registers.
// Frames are offered one per cycle with a valid strobe on the core clock.
`timescale 1ns/1ns
module pqm_mapper #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	input  wire logic              frame_valid_in,
	input  wire logic [2:0]        frame_pcp_in,
	input  wire logic              frame_use_dscp_in,
	input  wire logic [1:0]        frame_dscp_prio_in,
	output logic                   queue_valid_out,
	output logic [1:0]             queue_prio_out,
	output logic [1:0]             queue_num_out
);

	logic [7:0]  low_map_q;
	logic [7:0]  high_map_q;
	logic [1:0]  split_q;
	logic        two_queue_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic        qvalid_q;
	logic [1:0]  qprio_q;
	logic [1:0]  qnum_q;

	// Write channel capture, address and data in either order
	wire aw_take = s_axi_awvalid_in && !aw_have_q && !bvalid_q;
	wire w_take  = s_axi_wvalid_in && !w_have_q && !bvalid_q;
	wire wr_go   = aw_have_q && w_have_q && !bvalid_q;
	wire [ADDR_W-3:0] wr_idx = awaddr_q[ADDR_W-1:2];
	wire wr_low   = wr_go && wr_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_LOW_MAP);
	wire wr_high  = wr_go && wr_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_HIGH_MAP);
	wire wr_split = wr_go && wr_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_SPLIT);
	wire wr_mode  = wr_go && wr_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_MODE);
	wire wr_hit   = wr_low || wr_high || wr_split || wr_mode;
	wire lane0    = wstrb_q[0];

	assign s_axi_awready_out = !aw_have_q && !bvalid_q;
	assign s_axi_wready_out  = !w_have_q && !bvalid_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= pqm_pkg::PQM_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata_in;
				wstrb_q  <= s_axi_wstrb_in;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? pqm_pkg::PQM_RESP_OKAY
					: pqm_pkg::PQM_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_in) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// map fields reset to documented defaults
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_map_q   <= pqm_pkg::PQM_RST_LOW_MAP;
			high_map_q  <= pqm_pkg::PQM_RST_HIGH_MAP;
			split_q     <= pqm_pkg::PQM_RST_SPLIT;
			two_queue_q <= 1'b0;
		end else if (lane0) begin
			if (wr_low)
				low_map_q <= wdata_q[7:0];
			if (wr_high)
				high_map_q <= wdata_q[7:0];
			if (wr_split)
				split_q <= wdata_q[pqm_pkg::PQM_SPLIT_LSB +: 2];
			if (wr_mode)
				two_queue_q <= wdata_q[0];
		end
	end

	// Read path, one-cycle answer
	wire [ADDR_W-3:0] rd_idx = s_axi_araddr_in[ADDR_W-1:2];
	wire rd_low   = rd_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_LOW_MAP);
	wire rd_high  = rd_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_HIGH_MAP);
	wire rd_split = rd_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_SPLIT);
	wire rd_mode  = rd_idx == (ADDR_W-2)'(pqm_pkg::PQM_IDX_MODE);
	wire rd_hit   = rd_low || rd_high || rd_split || rd_mode;
	wire ar_take  = s_axi_arvalid_in && !rvalid_q;
	wire [31:0] rd_word =
		rd_low   ? {24'h000000, low_map_q} :
		rd_high  ? {24'h000000, high_map_q} :
		rd_split ? {24'h000000, split_q, 6'h00} :
		rd_mode  ? {31'h00000000, two_queue_q} : 32'h00000000;

	assign s_axi_arready_out = !rvalid_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= pqm_pkg::PQM_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? pqm_pkg::PQM_RESP_OKAY
				: pqm_pkg::PQM_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_in) begin
			rvalid_q <= 1'b0;
		end
	end

	// Classification
	wire [15:0] map_all = {high_map_q, low_map_q};
	wire [1:0]  pcp_prio = map_all[frame_pcp_in*pqm_pkg::PQM_FIELD_W +: 2];
	wire [1:0]  res = frame_use_dscp_in ? frame_dscp_prio_in : pcp_prio;
	// middle results follow their split bit
	wire        hi_mid = (res == 2'h1) ? split_q[0] : split_q[1];
	wire        two_hi = (res == 2'h3) ? 1'b1
		: (res == 2'h0) ? 1'b0 : hi_mid;
	wire [1:0]  qnum = two_queue_q ? {1'b0, two_hi} : res;

	// queue is fixed when the frame is classified
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			qvalid_q <= 1'b0;
			qprio_q  <= 2'h0;
			qnum_q   <= 2'h0;
		end else begin
			qvalid_q <= frame_valid_in;
			if (frame_valid_in) begin
				qprio_q <= res;
				qnum_q  <= qnum;
			end
		end
	end

	assign queue_valid_out = qvalid_q;
	assign queue_prio_out  = qprio_q;
	assign queue_num_out   = qnum_q;

	// pcp 0 maps through bits 1:0
	chk_pcp0_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h0
		|=> qprio_q == $past(low_map_q[1:0]))
		else $error("pcp0 priority wrong");
	chk_pcp1_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h1
		|=> qprio_q == $past(low_map_q[3:2]))
		else $error("pcp1 priority wrong");
	chk_pcp2_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h2
		|=> qprio_q == $past(low_map_q[5:4]))
		else $error("pcp2 priority wrong");
	chk_pcp3_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h3
		|=> qprio_q == $past(low_map_q[7:6]))
		else $error("pcp3 priority wrong");
	chk_pcp4_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h4
		|=> qprio_q == $past(high_map_q[1:0]))
		else $error("pcp4 priority wrong");
	chk_pcp5_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h5
		|=> qprio_q == $past(high_map_q[3:2]))
		else $error("pcp5 priority wrong");
	chk_pcp6_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h6
		|=> qprio_q == $past(high_map_q[5:4]))
		else $error("pcp6 priority wrong");
	chk_pcp7_field: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && !frame_use_dscp_in && frame_pcp_in == 3'h7
		|=> qprio_q == $past(high_map_q[7:6]))
		else $error("pcp7 priority wrong");
	chk_two_q_low: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && $past(two_queue_q) && qprio_q == 2'h0
		|-> qnum_q == 2'h0)
		else $error("result 0 not low");
	chk_two_q_high: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && $past(two_queue_q) && qprio_q == 2'h3
		|-> qnum_q == 2'h1)
		else $error("result 3 not high");
	chk_split_mid: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && $past(two_queue_q) && qprio_q == 2'h2
		|-> qnum_q == {1'b0, $past(split_q[1])})
		else $error("result 2 split wrong");
	// result 1 follows split bit 0
	chk_split_one: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && $past(two_queue_q) && qprio_q == 2'h1
		|-> qnum_q == {1'b0, $past(split_q[0])})
		else $error("result 1 split wrong");
	// two-queue answer is only low or high
	chk_two_q_range: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && $past(two_queue_q)
		|-> qnum_q[1] == 1'b0)
		else $error("two queue number out of range");
	chk_four_q_num: assert property (
		@(posedge clk_in) disable iff (rst_in)
		queue_valid_out && !$past(two_queue_q)
		|-> qnum_q == qprio_q)
		else $error("four queue number wrong");
	chk_dscp_src: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in && frame_use_dscp_in
		|=> qprio_q == $past(frame_dscp_prio_in))
		else $error("dscp result ignored");
	// every offered frame gets a queue
	chk_frame_steered: assert property (
		@(posedge clk_in) disable iff (rst_in)
		frame_valid_in
		|=> queue_valid_out)
		else $error("frame not steered");
	chk_map_update: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_low && lane0
		|=> low_map_q == $past(wdata_q[7:0]))
		else $error("map write lost");
	// high map write visible next cycle
	chk_high_update: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_high && lane0
		|=> high_map_q == $past(wdata_q[7:0]))
		else $error("high map write lost");
	// split taken from write data bits 7:6
	chk_split_update: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_split && lane0
		|=> split_q == $past(wdata_q[pqm_pkg::PQM_SPLIT_LSB +: 2]))
		else $error("split write lost");
	// settings change only through a write
	chk_map_hold: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!wr_go
		|=> $stable(low_map_q) && $stable(high_map_q) && $stable(split_q))
		else $error("settings changed without a write");
	// queued result kept until the next frame
	chk_queue_hold: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!frame_valid_in
		|=> $stable(qprio_q) && $stable(qnum_q))
		else $error("queued result changed");

endmodule // pqm_mapper

/* File: test/pqm_mapper_tb.sv */
// Self-checking bench for the 802.1p priority to queue mapper.
// Drives the AXI4-Lite and frame ports directly; no partner model.
`timescale 1ns/1ns
module pqm_mapper_tb;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, qv;
	logic [1:0]  bresp, rresp, qp, qn, dprio = '0;
	logic        fv = 0, use_d = 0;
	logic [2:0]  pcp = '0;
	logic [7:0]  lo_m = 8'h50, hi_m = 8'hfa;
	logic [1:0]  split = 2'h2, r;
	logic        mode = 1'b0;
	logic [31:0] st = 32'd92662, v;
	int          n_fail = 0, checked = 0, cyc = 0;

	pqm_mapper i_dut (.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .frame_valid_in(fv), .frame_pcp_in(pcp),
		.frame_use_dscp_in(use_d), .frame_dscp_prio_in(dprio),
		.queue_valid_out(qv), .queue_prio_out(qp), .queue_num_out(qn));

	always #5 clk_in = ~clk_in;

	// Hang guard, well above the expected run length
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction

	function automatic logic [11:0] adr(input logic [7:0] idx);
		return 12'({idx, 2'b00});
	endfunction

	function automatic logic [31:0] exp_reg(input logic [7:0] idx);
		case (idx)
			pqm_pkg::PQM_IDX_LOW_MAP:  return {24'h0, lo_m};
			pqm_pkg::PQM_IDX_HIGH_MAP: return {24'h0, hi_m};
			pqm_pkg::PQM_IDX_SPLIT:    return {24'h0, split, 6'h0};
			default:                   return {31'h0, mode};
		endcase
	endfunction

	function automatic logic [1:0] exp_prio(input logic [2:0] p,
		input logic u, input logic [1:0] d);
		logic [15:0] m;
		m = {hi_m, lo_m};
		return u ? d : m[2*p +: 2];
	endfunction

	// Two-queue answer: 0 low, 1 high
	function automatic logic [1:0] exp_q(input logic [1:0] res);
		if (!mode)
			return res;
		case (res)
			2'h0:    return 2'h0;
			2'h3:    return 2'h1;
			2'h1:    return {1'b0, split[0]};
			default: return {1'b0, split[1]};
		endcase
	endfunction

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] resp);
		bit aw_p, w_p, b_p;
		aw_p = 1;
		w_p = 1;
		b_p = 1;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_p || w_p || b_p) begin
			@(posedge clk_in);
			if (aw_p && awready) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
			if (b_p && bvalid) begin
				b_p = 0;
				resp = bresp;
				bready <= 1'b0;
			end
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		bit ar_p;
		ar_p = 1;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (ar_p && arready) begin
				ar_p = 0;
				arvalid <= 1'b0;
			end
		end while (!(rvalid && rready && !ar_p));
		rready <= 1'b0;
		chk("rresp", 32'(rresp), 32'(er));
		chk("rdata", rdata, e);
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
		axi_wr(adr(idx), d, 4'hf, r);
		chk("bresp", 32'(r), 32'(pqm_pkg::PQM_RESP_OKAY));
		case (idx)
			pqm_pkg::PQM_IDX_LOW_MAP:  lo_m = d[7:0];
			pqm_pkg::PQM_IDX_HIGH_MAP: hi_m = d[7:0];
			pqm_pkg::PQM_IDX_SPLIT:    split = d[7:6];
			default:                   mode = d[0];
		endcase
	endtask

	task automatic frame(input logic [2:0] p, input logic u,
		input logic [1:0] d);
		logic [1:0] e;
		e = exp_prio(p, u, d);
		@(posedge clk_in);
		fv <= 1'b1;
		pcp <= p;
		use_d <= u;
		dprio <= d;
		@(posedge clk_in);
		fv <= 1'b0;
		#1;
		chk("queue_valid", 32'(qv), 32'h1);
		chk("queue_prio", 32'(qp), 32'(e));
		chk("queue_num", 32'(qn), 32'(exp_q(e)));
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd_chk(adr(8'h80 + 8'(i)), exp_reg(8'h80 + 8'(i)), 2'h0);
		rd_chk(12'h210, 32'h0, pqm_pkg::PQM_RESP_SLVERR);
		for (int p = 0; p < 8; p++)
			frame(3'(p), 1'b0, 2'h0);
		axi_wr(adr(pqm_pkg::PQM_IDX_LOW_MAP), 32'hff, 4'h0, r);
		chk("bresp", 32'(r), 32'(pqm_pkg::PQM_RESP_OKAY));
		rd_chk(adr(pqm_pkg::PQM_IDX_LOW_MAP), 32'h50, 2'h0);
		axi_wr(12'h210, 32'hff, 4'hf, r);
		chk("bresp", 32'(r), 32'(pqm_pkg::PQM_RESP_SLVERR));
		reg_wr(pqm_pkg::PQM_IDX_MODE, 32'h1);
		for (int s = 0; s < 4; s++) begin
			if (s == 1)
				continue;
			reg_wr(pqm_pkg::PQM_IDX_SPLIT, 32'(s << 6));
			for (int q = 0; q < 4; q++)
				frame(3'(rnd()), 1'b1, 2'(q));
		end
		for (int i = 0; i < 40; i++) begin
			v = rnd();
			if (v[9:8] == 2'h2 && v[7:6] == 2'h1)
				v[6] = 1'b1;
			reg_wr(8'h80 + 8'(v[9:8]), {24'h0, v[7:0]});
			for (int k = 0; k < 3; k++) begin
				v = rnd();
				frame(v[2:0], v[3], v[5:4]);
			end
			rd_chk(adr(8'h80 + 8'(i % 4)), exp_reg(8'h80 + 8'(i % 4)), 2'h0);
		end
		// Mid-run reset must bring back the defaults
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		lo_m = pqm_pkg::PQM_RST_LOW_MAP;
		hi_m = pqm_pkg::PQM_RST_HIGH_MAP;
		split = pqm_pkg::PQM_RST_SPLIT;
		mode = 1'b0;
		for (int i = 0; i < 4; i++)
			rd_chk(adr(8'h80 + 8'(i)), exp_reg(8'h80 + 8'(i)), 2'h0);
		for (int p = 0; p < 8; p++)
			frame(3'(p), 1'b0, 2'h0);
		stop_test();
	end
endmodule // pqm_mapper_tb
